/* File: design/phymac_phy_end.sv */
// PHY end of the MAC data port: receive presentation and transmit capture.
// Assumes media words arrive on ref_clk and the link clock comes from outside.
`timescale 1ns/1ns
// Functional notes
// (RULE1) No RMII receive error at 10 Mbps.
// (RULE2) 10M RMII outputs change once per ten clocks.
// (RULE3) 100M RMII transmit data valid only with enable.
// (RULE4) Odd final 100M RMII di-bit dropped.
// (RULE5) MAC repeats each 10M di-bit ten clocks.
// (RULE6) 10M preamble padded to nibble-align delimiter.
// (RULE7) Trailing partial nibble truncated at 10M.
// (RULE8) MII valid data: data-valid high, nibbles out.
// (RULE9) MII invalid: data-valid low, zero data.
// (RULE10) MII carrier sense asserts without clock edge.
// (RULE11) False carrier: nibble 1110 with error flag.
// (RULE12) 100M symbol error: nibbles replaced by 0101.
// (RULE13) MII receive error low at 10 Mbps.
// (RULE14) MAC drives MII transmit at link clock.
// (RULE15) MII transmit data valid only with enable.
// (RULE16) Half duplex collision drives collision output.
// (RULE17) GPSI: serial data; invalid drops carrier, zero.
// (RULE18) MAC drives GPSI transmit on link clock.
// (RULE19) GPSI transmit sampled only with enable.
// (RULE20) RMII synchronous except carrier assertion.
// (RULE21) Drain: data-valid low first, high second.
// (RULE22) Buffer 12 bits first; drive 00 meanwhile.
// (RULE23) One static interface mode at a time.
module phymac_phy_end #(
	parameter int ADDR_W = 3
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	phymac_if.phy link,
	input wire phymac_pkg::phymac_mode_e ifMode,
	input wire logic speed10,
	input wire logic halfDuplex,
	input wire logic mediaCarrier,
	input wire logic mediaCollision,
	input wire logic mediaRxValid,
	input wire logic [3:0] mediaRxData,
	input wire logic [1:0] mediaRxCode,
	output logic mediaRxReady,
	output logic mediaTxValid,
	output logic [3:0] mediaTxData,
	output logic mediaTxEnd
);
	localparam int DEPTH = 1 << ADDR_W;
	typedef enum {RX_IDLE, RX_FILL, RX_SEND} phymac_rxstate_e;

	function automatic logic [ADDR_W:0] bin2gray(input logic [ADDR_W:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [ADDR_W:0] gray2bin(input logic [ADDR_W:0] g);
		logic [ADDR_W:0] b;
		b = g;
		for (int i = ADDR_W - 1; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		gray2bin = b;
	endfunction

	logic [5:0] fifoMem [DEPTH];
	logic [ADDR_W:0] wrBin, wrGray, rdBin, rdGray;
	logic [ADDR_W:0] rdGraySync1, rdGraySync2, wrGraySync1, wrGraySync2;
	logic carrierRef;
	logic [3:0] cfgSync1, cfgSync2;
	logic carrierSync1, carrierSync2, collSync1, collSync2;
	logic [3:0] holdCnt, sampCnt;
	logic [1:0] phase, unitCnt;
	logic [5:0] curWord;
	logic [3:0] rxdReg, acc;
	logic rxDvReg, crsDvReg, crsReg, rxErReg, colReg;
	logic txActive, inPre;
	phymac_rxstate_e rxState;

	// Write side of the receive FIFO; this FIFO is the resynchroniser.
	wire writeNow = mediaRxValid && mediaRxReady;
	wire [ADDR_W:0] next_wrBin = wrBin + 1'b1;
	wire [ADDR_W:0] next_wrGray = writeNow ? bin2gray(next_wrBin) : wrGray;
	wire [ADDR_W:0] fullGray = {~rdGraySync2[ADDR_W:ADDR_W - 1],
		rdGraySync2[ADDR_W - 2:0]};
	wire rmiiRef = ifMode == phymac_pkg::PHYMAC_RMII;

	// Media side pointers; ready is registered from the post-write state.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrBin <= '0;
			wrGray <= '0;
			rdGraySync1 <= '0;
			rdGraySync2 <= '0;
			mediaRxReady <= 1'b0;
			carrierRef <= 1'b0;
		end else begin
			rdGraySync1 <= rdGray;
			rdGraySync2 <= rdGraySync1;
			if (writeNow) begin
				wrBin <= next_wrBin;
			end
			wrGray <= next_wrGray;
			mediaRxReady <= next_wrGray != fullGray;
			carrierRef <= mediaCarrier;
		end
	end

	// FIFO storage holds code and nibble of each received word.
	always_ff @(posedge ref_clk) begin
		if (writeNow) begin
			fifoMem[wrBin[ADDR_W - 1:0]] <= {mediaRxCode, mediaRxData};
		end
	end

	// Static configuration seen in the link domain.
	wire isRmii = cfgSync2[1:0] == phymac_pkg::PHYMAC_RMII; // (RULE23)
	wire isGpsi = cfgSync2[1:0] == phymac_pkg::PHYMAC_GPSI;
	wire is10 = cfgSync2[2];
	wire slow = isRmii && is10;
	wire [1:0] lastUnit = isRmii ? phymac_pkg::LAST_UNIT_RMII :
		isGpsi ? phymac_pkg::LAST_UNIT_GPSI : phymac_pkg::LAST_UNIT_MII;

	// Read side status and the word at the head of the FIFO.
	wire fifoEmpty = wrGraySync2 == rdGray;
	wire [ADDR_W:0] rdLevel = gray2bin(wrGraySync2) - rdBin;
	wire [5:0] headWord = fifoMem[rdBin[ADDR_W - 1:0]];
	wire [ADDR_W:0] next_rdBin = rdBin + 1'b1;
	wire stepTick = holdCnt == 4'h0; // (RULE2)
	wire enough = rdLevel >= (ADDR_W + 1)'(phymac_pkg::FILL_NIBBLES);
	wire startSend = !fifoEmpty && (enough || !carrierSync2); // (RULE22)
	wire lastPhase = phase == lastUnit;
	wire popNow = stepTick && ((rxState == RX_FILL && startSend) ||
		(rxState == RX_SEND && lastPhase && !fifoEmpty));

	// Substitution of false carrier and symbol error nibbles at 100M.
	wire [1:0] curCode = curWord[5:4];
	wire errNow = curCode == phymac_pkg::CODE_FALSE && !is10; // (RULE1)
	wire symNow = curCode == phymac_pkg::CODE_SYMERR && !is10;
	wire [3:0] outNib = errNow ? phymac_pkg::FALSE_NIBBLE : // (RULE11)
		symNow ? phymac_pkg::SYMERR_NIBBLE : curWord[3:0]; // (RULE12)
	wire [3:0] slice = isRmii ? {2'b00, phase[0] ? outNib[3:2] :
		outNib[1:0]} : isGpsi ? {3'b000, outNib[phase]} : outNib;
	// Drain pattern: low on first di-bit, high on second if more waits.
	wire sendCrsDv = carrierSync2 || (phase[0] && !fifoEmpty); // (RULE21)

	// Link domain synchronisers, FIFO read pointer and step timer.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			wrGraySync1 <= '0;
			wrGraySync2 <= '0;
			cfgSync1 <= 4'h0;
			cfgSync2 <= 4'h0;
			carrierSync1 <= 1'b0;
			carrierSync2 <= 1'b0;
			collSync1 <= 1'b0;
			collSync2 <= 1'b0;
			rdBin <= '0;
			rdGray <= '0;
			holdCnt <= 4'h0;
		end else begin
			wrGraySync1 <= wrGray;
			wrGraySync2 <= wrGraySync1;
			cfgSync1 <= {halfDuplex, speed10, ifMode};
			cfgSync2 <= cfgSync1;
			carrierSync1 <= mediaCarrier;
			carrierSync2 <= carrierSync1;
			collSync1 <= mediaCollision;
			collSync2 <= collSync1;
			if (popNow) begin
				rdBin <= next_rdBin;
				rdGray <= bin2gray(next_rdBin);
			end
			holdCnt <= !stepTick ? holdCnt - 4'h1 :
				slow ? phymac_pkg::HOLD_LAST_10M : 4'h0; // (RULE2)
		end
	end

	// Receive sequencer; every change waits for a step tick.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			rxState <= RX_IDLE;
			phase <= 2'h0;
			curWord <= 6'h00;
			rxdReg <= 4'h0;
			rxDvReg <= 1'b0;
			crsDvReg <= 1'b0;
			crsReg <= 1'b0;
			rxErReg <= 1'b0;
		end else if (stepTick) begin
			case (rxState)
				RX_IDLE: begin
					rxdReg <= phymac_pkg::IDLE_NIBBLE; // (RULE9)
					rxDvReg <= 1'b0;
					rxErReg <= 1'b0;
					crsDvReg <= isRmii && carrierSync2;
					crsReg <= !isRmii && !isGpsi && carrierSync2;
					if (carrierSync2 || !fifoEmpty) begin
						rxState <= RX_FILL;
					end
				end
				RX_FILL: begin
					rxdReg <= phymac_pkg::IDLE_NIBBLE; // (RULE22)
					crsDvReg <= isRmii && carrierSync2;
					crsReg <= !isRmii && !isGpsi && carrierSync2;
					if (startSend) begin
						curWord <= headWord;
						phase <= 2'h0;
						rxState <= RX_SEND;
					end else if (!carrierSync2) begin
						rxState <= RX_IDLE;
					end
				end
				RX_SEND: begin
					rxdReg <= slice; // (RULE8) (RULE17)
					rxDvReg <= !isRmii && !isGpsi; // (RULE8)
					rxErReg <= !isRmii && !isGpsi && errNow; // (RULE13)
					crsDvReg <= isRmii && sendCrsDv; // (RULE21)
					crsReg <= !isRmii; // (RULE17)
					if (!lastPhase) begin
						phase <= phase + 2'h1;
					end else if (!fifoEmpty) begin
						curWord <= headWord;
						phase <= 2'h0;
					end else begin
						rxState <= RX_IDLE;
					end
				end
				default: begin
					rxState <= RX_IDLE;
				end
			endcase
		end
	end

	// Collision is reported only in half duplex.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			colReg <= 1'b0;
		end else begin
			colReg <= cfgSync2[3] && collSync2; // (RULE16)
		end
	end

	// Carrier asserts straight from the media flop, not on a link edge.
	assign link.rxd = rxdReg;
	assign link.rxDv = rxDvReg;
	assign link.rxEr = rxErReg; // (RULE1) (RULE13)
	assign link.col = colReg;
	assign link.crsDv = crsDvReg || (carrierRef && rmiiRef); // (RULE20)
	assign link.crs = crsReg || (carrierRef && !rmiiRef); // (RULE10)

	// Transmit sampling: at 10M RMII one sample mid-way in each repeat.
	wire sampleNow = link.txEn &&
		(!slow || sampCnt == phymac_pkg::SAMPLE_POINT); // (RULE3) (RULE5)
	wire [3:0] nextAcc = isRmii ? {link.txd[1:0], acc[3:2]} :
		isGpsi ? {link.txd[0], acc[3:1]} : link.txd; // (RULE15) (RULE19)
	wire alignSfd = slow && inPre &&
		link.txd[1:0] == phymac_pkg::SFD_DIBIT; // (RULE6)
	wire emitNow = sampleNow && (alignSfd || unitCnt == lastUnit);

	// Transmit assembly; a partial nibble at enable fall is discarded.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			txActive <= 1'b0;
			inPre <= 1'b1;
			sampCnt <= 4'h0;
			unitCnt <= 2'h0;
			acc <= 4'h0;
			mediaTxValid <= 1'b0;
			mediaTxData <= 4'h0;
			mediaTxEnd <= 1'b0;
		end else begin
			txActive <= link.txEn;
			mediaTxEnd <= txActive && !link.txEn; // (RULE4) (RULE7)
			mediaTxValid <= emitNow;
			if (!link.txEn) begin
				sampCnt <= 4'h0;
				unitCnt <= 2'h0;
				acc <= 4'h0;
				inPre <= 1'b1;
			end else begin
				sampCnt <= sampCnt == phymac_pkg::HOLD_LAST_10M ? 4'h0 :
					sampCnt + 4'h1;
				if (sampleNow && alignSfd) begin
					mediaTxData <= {phymac_pkg::SFD_DIBIT,
						phymac_pkg::PRE_DIBIT}; // (RULE6)
					unitCnt <= 2'h0;
					inPre <= 1'b0;
				end else if (emitNow) begin
					mediaTxData <= nextAcc;
					unitCnt <= 2'h0;
				end else if (sampleNow) begin
					acc <= nextAcc;
					unitCnt <= unitCnt + 2'h1;
				end
			end
		end
	end
endmodule // phymac_phy_end

/* File: design/phymac_pkg.sv */
// Shared constants and types for both ends of the PHY to MAC data port.
// Assumes both ends and the bench agree on one static interface mode.
package phymac_pkg;

	// Selected MAC interface flavour.
	typedef enum logic [1:0] {PHYMAC_RMII, PHYMAC_MII, PHYMAC_GPSI} phymac_mode_e;

	// Receive word codes written by the media side into the receive FIFO.
	localparam logic [1:0] CODE_DATA = 2'h0;
	localparam logic [1:0] CODE_SYMERR = 2'h1;
	localparam logic [1:0] CODE_FALSE = 2'h2;

	// Substitute nibbles and idle receive value.
	localparam logic [3:0] FALSE_NIBBLE = 4'he;
	localparam logic [3:0] SYMERR_NIBBLE = 4'h5;
	localparam logic [3:0] IDLE_NIBBLE = 4'h0;

	// Preamble and delimiter di-bits as seen on the 2-bit link.
	localparam logic [1:0] PRE_DIBIT = 2'h1;
	localparam logic [1:0] SFD_DIBIT = 2'h3;

	// Each 10 Mbps RMII di-bit lasts ten link clocks; last count is nine.
	localparam logic [3:0] HOLD_LAST_10M = 4'h9;
	// Count within a repeated di-bit at which the receiver samples it.
	localparam logic [3:0] SAMPLE_POINT = 4'h4;
	// Nibbles (12 bits) buffered before receive data is presented.
	localparam logic [3:0] FILL_NIBBLES = 4'h3;

	// Units per nibble minus one: 2-bit, 4-bit and serial links.
	localparam logic [1:0] LAST_UNIT_RMII = 2'h1;
	localparam logic [1:0] LAST_UNIT_MII = 2'h0;
	localparam logic [1:0] LAST_UNIT_GPSI = 2'h3;

endpackage

/* File: design/phymac_if.sv */
// Link wires between the PHY end and the MAC end of the data port.
// Assumes the bench drives linkClk; all wires are single driver.
`timescale 1ns/1ns
interface phymac_if (
	input wire logic linkClk
);
	logic txEn;
	logic [3:0] txd;
	logic [3:0] rxd;
	logic rxDv;
	logic crsDv;
	logic crs;
	logic rxEr;
	logic col;

	modport phy (
		input linkClk,
		input txEn,
		input txd,
		output rxd,
		output rxDv,
		output crsDv,
		output crs,
		output rxEr,
		output col
	);

	modport mac (
		input linkClk,
		output txEn,
		output txd,
		input rxd,
		input rxDv,
		input crsDv,
		input crs,
		input rxEr,
		input col
	);
endinterface // phymac_if

/* File: design/phymac_mac_end.sv */
// MAC end of the data port: serialises nibbles out, gathers nibbles in.
// Assumes the bench supplies the link clock; user side runs on it too.
`timescale 1ns/1ns
module phymac_mac_end (
	input wire logic rst_n,
	phymac_if.mac link,
	input wire phymac_pkg::phymac_mode_e ifMode,
	input wire logic speed10,
	input wire logic sendValid,
	input wire logic [3:0] sendData,
	input wire logic sendLast,
	output logic sendTaken,
	output logic recvValid,
	output logic [3:0] recvData,
	output logic recvErr,
	output logic recvEnd,
	output logic carrierSeen,
	output logic collisionSeen
);
	typedef enum {TX_IDLE, TX_RUN, TX_DONE} phymac_txstate_e;

	phymac_txstate_e txState;
	logic [3:0] txHold, rxCnt, curNib, txdReg, acc;
	logic [1:0] txPhase, rxPhase;
	logic curLast, txEnReg, inFrame, prevDv, errAcc;
	logic [8:0] pipe1, pipe2;

	wire isRmii = ifMode == phymac_pkg::PHYMAC_RMII;
	wire isGpsi = ifMode == phymac_pkg::PHYMAC_GPSI;
	wire slow = isRmii && speed10;
	wire [1:0] lastUnit = isRmii ? phymac_pkg::LAST_UNIT_RMII :
		isGpsi ? phymac_pkg::LAST_UNIT_GPSI : phymac_pkg::LAST_UNIT_MII;
	wire txTick = txHold == 4'h0;
	wire [3:0] txSlice = isRmii ? {2'b00, txPhase[0] ? curNib[3:2] :
		curNib[1:0]} : isGpsi ? {3'b000, curNib[txPhase]} : curNib;
	wire loadNext = txState == TX_RUN && txTick && txPhase == lastUnit &&
		!curLast && sendValid;
	wire loadFirst = txState == TX_IDLE && sendValid;

	// Transmit: each unit repeated ten clocks at 10M RMII.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			txState <= TX_IDLE;
			txHold <= 4'h0;
			txPhase <= 2'h0;
			curNib <= 4'h0;
			curLast <= 1'b0;
			txEnReg <= 1'b0;
			txdReg <= 4'h0;
			sendTaken <= 1'b0;
		end else begin
			sendTaken <= loadFirst || loadNext;
			txHold <= txState == TX_IDLE || !txTick ? (txTick ? 4'h0 :
				txHold - 4'h1) : slow ? phymac_pkg::HOLD_LAST_10M : 4'h0;
			if (loadFirst || loadNext) begin
				curNib <= sendData;
				curLast <= sendLast;
				txPhase <= 2'h0;
			end
			case (txState)
				TX_IDLE: begin
					if (sendValid) begin
						txState <= TX_RUN;
					end
				end
				TX_RUN: begin
					if (txTick) begin
						txEnReg <= 1'b1;
						txdReg <= txSlice;
						if (txPhase != lastUnit) begin
							txPhase <= txPhase + 2'h1;
						end else if (!loadNext) begin
							txState <= TX_DONE;
						end
					end
				end
				TX_DONE: begin
					if (txTick) begin
						txEnReg <= 1'b0;
						txdReg <= 4'h0;
						txState <= TX_IDLE;
					end
				end
				default: begin
					txState <= TX_IDLE;
				end
			endcase
		end
	end

	assign link.txEn = txEnReg; // (RULE5) (RULE14) (RULE18)
	assign link.txd = txdReg; // (RULE14) (RULE18)

	// Receive pins pass two flops; carrier may rise off the clock edge.
	wire [3:0] pRxd = pipe2[3:0];
	wire pDv = pipe2[4];
	wire pCrsDv = pipe2[5];
	wire pCrs = pipe2[6];
	wire pErr = pipe2[7];
	wire rxTick = !slow || rxCnt == phymac_pkg::HOLD_LAST_10M;
	wire frameStart = isRmii ? pCrsDv && pRxd[1:0] == phymac_pkg::PRE_DIBIT :
		isGpsi ? pCrs && pRxd[0] : pDv;
	wire frameStop = isRmii ? !pCrsDv && !prevDv && rxPhase == 2'h0 :
		isGpsi ? !pCrs : !pDv;
	wire [3:0] nextAcc = isRmii ? {pRxd[1:0], acc[3:2]} :
		isGpsi ? {pRxd[0], acc[3:1]} : pRxd;
	wire takeUnit = inFrame ? rxTick && !frameStop : frameStart;

	// Receive gathering of units into nibbles, low unit first.
	always_ff @(posedge link.linkClk or negedge rst_n) begin
		if (!rst_n) begin
			pipe1 <= 9'h000;
			pipe2 <= 9'h000;
			inFrame <= 1'b0;
			rxCnt <= 4'h0;
			rxPhase <= 2'h0;
			acc <= 4'h0;
			prevDv <= 1'b0;
			errAcc <= 1'b0;
			recvValid <= 1'b0;
			recvData <= 4'h0;
			recvErr <= 1'b0;
			recvEnd <= 1'b0;
			carrierSeen <= 1'b0;
			collisionSeen <= 1'b0;
		end else begin
			pipe1 <= {link.col, link.rxEr, link.crs, link.crsDv, link.rxDv,
				link.rxd};
			pipe2 <= pipe1;
			carrierSeen <= isRmii ? pCrsDv : pCrs;
			collisionSeen <= pipe2[8];
			rxCnt <= !inFrame || rxCnt == phymac_pkg::HOLD_LAST_10M ? 4'h0 :
				rxCnt + 4'h1;
			recvValid <= 1'b0;
			recvEnd <= inFrame && rxTick && frameStop;
			if (inFrame && rxTick && frameStop) begin
				inFrame <= 1'b0;
				rxPhase <= 2'h0;
			end else if (takeUnit) begin
				inFrame <= 1'b1;
				if (rxPhase[0]) begin
					prevDv <= pCrsDv;
				end
				if (rxPhase == lastUnit) begin
					recvValid <= 1'b1;
					recvData <= nextAcc;
					recvErr <= errAcc || pErr;
					errAcc <= 1'b0;
					rxPhase <= 2'h0;
				end else begin
					acc <= nextAcc;
					errAcc <= errAcc || pErr;
					rxPhase <= rxPhase + 2'h1;
				end
			end
		end
	end
endmodule // phymac_mac_end

/* File: verification/phymac_link_asserts.sv */
// Checker for the link wires that join the PHY end and the MAC end.
// Assumes mode inputs are static outside reset and rst_n is async low.
`timescale 1ns/1ns
module phymac_link_asserts (
	input wire logic linkClk,
	input wire logic rst_n,
	input wire phymac_pkg::phymac_mode_e ifMode,
	input wire logic speed10,
	input wire logic txEn,
	input wire logic [3:0] txd,
	input wire logic [3:0] rxd,
	input wire logic rxDv,
	input wire logic crsDv,
	input wire logic crs,
	input wire logic rxEr
);
	// Mode decodes shared by the properties.
	wire isRmii = (ifMode == phymac_pkg::PHYMAC_RMII);
	wire isMii = (ifMode == phymac_pkg::PHYMAC_MII);
	wire isGpsi = (ifMode == phymac_pkg::PHYMAC_GPSI);
	wire slowRmii = isRmii && speed10;
	logic [3:0] quiet;
	logic [1:0] prevRxd;
	logic prevCrsDv;
	// A receive pin move is a data change or a synchronous carrier drop.
	wire rxMoved = (rxd[1:0] != prevRxd) || (prevCrsDv && !crsDv);

	// Counts quiet clocks since the last move; saturates so it never wraps.
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 4'hf;
			prevRxd <= 2'h0;
			prevCrsDv <= 1'b0;
		end else begin
			quiet <= rxMoved ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
			prevRxd <= rxd[1:0];
			prevCrsDv <= crsDv;
		end
	end

	default clocking linkCb @(posedge linkClk);
	endclocking
	default disable iff (!rst_n);

	// One transmit di-bit still on the wire with the enable held.
	sequence dibitHeld;
		txEn && $stable(txd[1:0]);
	endsequence
	// Nine further clocks of the same di-bit make ten in all.
	sequence tenClocks;
		dibitHeld [*8] ##1 dibitHeld;
	endsequence

	a_rmii10_no_err: assert property (slowRmii |-> !rxEr)
		else $error("receive error raised in slow 2-bit mode");
	a_rmii10_rx_hold: assert property (slowRmii && rxMoved |-> quiet >= 4'h9)
		else $error("slow 2-bit receive pins moved too early");
	a_tx_dibit_hold: assert property (slowRmii && $rose(txEn) |=> tenClocks)
		else $error("slow 2-bit transmit di-bit not held ten clocks");
	a_rmii_fill_zero: assert property (isRmii && !speed10 && $rose(crsDv) && !$past(crsDv, 2) |-> rxd[1:0] == 2'h0)
		else $error("2-bit receive data not zero at carrier start");
	a_mii_idle_zero: assert property (isMii && !rxDv && !rxEr |-> rxd == phymac_pkg::IDLE_NIBBLE)
		else $error("4-bit receive data not zero while invalid");
	a_false_nibble: assert property (isMii && rxEr |-> rxd == phymac_pkg::FALSE_NIBBLE)
		else $error("receive error without the false carrier nibble");
	a_mii10_no_err: assert property (isMii && speed10 |-> !rxEr)
		else $error("receive error raised in slow 4-bit mode");
	a_mii_dv_crs: assert property (isMii && rxDv |-> crs)
		else $error("data valid without carrier sense");
	a_gpsi_idle_zero: assert property (isGpsi && !crs |-> rxd[0] == 1'b0)
		else $error("serial receive line not zero without carrier");
	a_one_mode_only: assert property (!isMii |-> !rxDv)
		else $error("data valid driven outside 4-bit mode");
endmodule // phymac_link_asserts

/* File: verification/tb.sv */
// Testbench: both ends joined by the link, a queue model checks traffic.
// Assumes the design files and package compile first.
`timescale 1ns/1ns
module tb;
	logic ref_clk = 1'b0;
	logic linkClk = 1'b0;
	logic rst_n = 1'b0;
	logic speed10 = 1'b0;
	logic halfDuplex = 1'b1;
	logic mediaCarrier = 1'b0;
	logic mediaCollision = 1'b0;
	logic mediaRxValid = 1'b0;
	logic [3:0] mediaRxData = 4'h0;
	logic [1:0] mediaRxCode = 2'h0;
	logic sendValid = 1'b0;
	logic [3:0] sendData = 4'h0;
	logic sendLast = 1'b0;
	phymac_pkg::phymac_mode_e ifMode = phymac_pkg::PHYMAC_MII;
	logic mediaRxReady, mediaTxValid, mediaTxEnd, sendTaken, recvValid;
	logic recvErr, recvEnd, carrierSeen, collisionSeen;
	logic [3:0] mediaTxData, recvData, ex;
	logic rxChk = 1'b1;
	logic erSeen = 1'b0;
	int error_cnt = 0;
	int check_count = 0;
	int txEnds = 0;
	int rxEnds = 0;
	int crsHits = 0;
	logic [3:0] rxExp[$];
	logic [3:0] txExp[$];
	phymac_pkg::phymac_mode_e modeTab[5] = '{phymac_pkg::PHYMAC_MII,
		phymac_pkg::PHYMAC_MII, phymac_pkg::PHYMAC_RMII,
		phymac_pkg::PHYMAC_RMII, phymac_pkg::PHYMAC_GPSI};
	logic spdTab[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	// Media clock and an unrelated link clock.
	initial forever #5 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #6 linkClk = ~linkClk;
	end

	phymac_if u_phymac_if (.linkClk(linkClk));

	phymac_phy_end u_phymac_phy_end (.ref_clk(ref_clk), .rst_n(rst_n),
		.link(u_phymac_if.phy), .ifMode(ifMode), .speed10(speed10),
		.halfDuplex(halfDuplex), .mediaCarrier(mediaCarrier),
		.mediaCollision(mediaCollision), .mediaRxValid(mediaRxValid),
		.mediaRxData(mediaRxData), .mediaRxCode(mediaRxCode),
		.mediaRxReady(mediaRxReady), .mediaTxValid(mediaTxValid),
		.mediaTxData(mediaTxData), .mediaTxEnd(mediaTxEnd));

	phymac_mac_end u_phymac_mac_end (.rst_n(rst_n), .link(u_phymac_if.mac),
		.ifMode(ifMode), .speed10(speed10), .sendValid(sendValid),
		.sendData(sendData), .sendLast(sendLast), .sendTaken(sendTaken),
		.recvValid(recvValid), .recvData(recvData), .recvErr(recvErr),
		.recvEnd(recvEnd), .carrierSeen(carrierSeen),
		.collisionSeen(collisionSeen));

	phymac_link_asserts u_phymac_link_asserts (.linkClk(linkClk),
		.rst_n(rst_n), .ifMode(ifMode), .speed10(speed10),
		.txEn(u_phymac_if.txEn), .txd(u_phymac_if.txd),
		.rxd(u_phymac_if.rxd), .rxDv(u_phymac_if.rxDv),
		.crsDv(u_phymac_if.crsDv), .crs(u_phymac_if.crs),
		.rxEr(u_phymac_if.rxEr));

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Resets both ends with a new static mode and lets the config settle.
	task automatic setup(input phymac_pkg::phymac_mode_e m, input logic s10);
		@(negedge ref_clk);
		rst_n = 1'b0;
		ifMode = m;
		speed10 = s10;
		repeat (2) @(posedge linkClk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(posedge linkClk);
	endtask

	// Feeds one media frame and queues what the MAC end must gather.
	task automatic rx_frame(input int n, input int bad, input logic [1:0] code);
		logic [3:0] d;
		int k;
		int ends;
		int hits;
		ends = rxEnds;
		hits = crsHits;
		@(negedge ref_clk);
		mediaCarrier = 1'b1;
		for (int i = 0; i < n; i++) begin
			d = (i < 3) ? 4'h5 : ((i == 3) ? 4'hd : 4'($urandom()));
			mediaRxValid = 1'b1;
			mediaRxData = d;
			mediaRxCode = (i == bad) ? code : 2'h0;
			if (i == bad && !speed10 && code == phymac_pkg::CODE_SYMERR) begin
				d = phymac_pkg::SYMERR_NIBBLE;
			end
			rxExp.push_back(d);
			k = 0;
			do begin
				@(posedge ref_clk);
				k++;
			end while (mediaRxReady !== 1'b1 && k < 500);
			@(negedge ref_clk);
		end
		mediaRxValid = 1'b0;
		mediaRxCode = 2'h0;
		mediaCarrier = 1'b0;
		if (!rxChk) begin
			rxExp.delete();
		end
		for (k = 0; k < 3000 && (rxExp.size() != 0 || rxEnds == ends); k++) begin
			@(posedge linkClk);
		end
		check(8'(rxExp.size()), 8'h0);
		check(8'(rxEnds - ends), 8'h1);
		check({7'h0, crsHits != hits}, 8'h1);
		rxExp.delete();
	endtask

	// Sends one frame from the MAC end and queues what the PHY end emits.
	task automatic tx_frame(input int n);
		int k;
		int ends;
		ends = txEnds;
		@(negedge linkClk);
		for (int i = 0; i < n; i++) begin
			sendValid = 1'b1;
			sendData = (i < 3) ? 4'h5 : ((i == 3) ? 4'hd : 4'($urandom()));
			sendLast = (i == n - 1);
			txExp.push_back(sendData);
			k = 0;
			// The take happens on the edge before the pulse shows.
			do begin
				@(negedge linkClk);
				k++;
			end while (sendTaken !== 1'b1 && k < 400);
		end
		sendValid = 1'b0;
		sendLast = 1'b0;
		for (k = 0; k < 900 && (txExp.size() != 0 || txEnds == ends); k++) begin
			@(posedge linkClk);
		end
		check(8'(txExp.size()), 8'h0);
		check(8'(txEnds - ends), 8'h1);
	endtask

	// Compares gathered and emitted nibbles mid-cycle, where they are settled.
	always @(negedge linkClk) begin
		if (u_phymac_if.rxEr === 1'b1) erSeen = 1'b1;
		if (carrierSeen === 1'b1) crsHits++;
		if (recvEnd === 1'b1) rxEnds++;
		if (recvValid === 1'b1 && rxChk) begin
			ex = (rxExp.size() != 0) ? rxExp.pop_front() : 4'hx;
			check({3'h0, recvErr, recvData}, {4'h0, ex});
		end
		if (mediaTxValid === 1'b1) begin
			ex = (txExp.size() != 0) ? txExp.pop_front() : 4'hx;
			check({4'h0, mediaTxData}, {4'h0, ex});
		end
		if (mediaTxEnd === 1'b1) txEnds++;
	end

	// Cuts a hang short; the span is well above the longest mode run.
	initial begin
		#400000;
		error_cnt++;
		results();
	end

	// Main sequence: every mode both ways, then fault and collision cases.
	initial begin
		void'($urandom(32'hf7421706));
		for (int m = 0; m < 5; m++) begin
			setup(modeTab[m], spdTab[m]);
			rx_frame(12, 6, phymac_pkg::CODE_SYMERR);
			tx_frame(10);
		end
		setup(phymac_pkg::PHYMAC_MII, 1'b0);
		rxChk = 1'b0;
		erSeen = 1'b0;
		rx_frame(1, 0, phymac_pkg::CODE_FALSE);
		for (int k = 0; k < 200 && !erSeen; k++) @(posedge linkClk);
		check({7'h0, erSeen}, 8'h1);
		rxChk = 1'b1;
		@(negedge ref_clk);
		mediaCollision = 1'b1;
		repeat (8) @(posedge linkClk);
		check({6'h0, u_phymac_if.col, collisionSeen}, 8'h3);
		@(negedge ref_clk);
		mediaCollision = 1'b0;
		repeat (8) @(posedge linkClk);
		check({7'h0, u_phymac_if.col}, 8'h0);
		// False carrier at 10M passes as plain data with no error flag.
		setup(phymac_pkg::PHYMAC_MII, 1'b1);
		erSeen = 1'b0;
		rx_frame(1, 0, phymac_pkg::CODE_FALSE);
		check({7'h0, erSeen}, 8'h0);
		results();
	end
endmodule // tb
